// *** rtl/pwtcp_consts.vh ***
// Purpose: constants for the pulse width timer with complementary pwm
// Assumes: plain register port, 16-bit data
// Notes:   offsets are register indexes on the port
`ifndef PWTCP_CONSTS_VH
`define PWTCP_CONSTS_VH
`define PWTCP_A_MCNT     5'h00
`define PWTCP_A_MCLK     5'h01
`define PWTCP_A_MCAP     5'h02
`define PWTCP_A_MIOC     5'h03
`define PWTCP_A_MIEN     5'h04
`define PWTCP_A_MSTART   5'h05
`define PWTCP_A_MCLREN   5'h06
`define PWTCP_A_MSTAT    5'h07
`define PWTCP_A_PSTART   5'h08
`define PWTCP_A_CNT1     5'h09
`define PWTCP_A_CNT2     5'h0A
`define PWTCP_A_UPLIM    5'h0B
`define PWTCP_A_UPBUF    5'h0C
`define PWTCP_A_DUTY1    5'h0D
`define PWTCP_A_DUTY2    5'h0E
`define PWTCP_A_DUTY3    5'h0F
`define PWTCP_A_DBUF1    5'h10
`define PWTCP_A_DBUF2    5'h11
`define PWTCP_A_DBUF3    5'h12
`define PWTCP_A_DEAD     5'h13
`define PWTCP_A_HALF     5'h14
`define PWTCP_A_HBUF     5'h15
`define PWTCP_A_SKIPSET  5'h16
`define PWTCP_A_SKIPCNT  5'h17
`define PWTCP_A_BTSET    5'h18
`define PWTCP_A_ADCTL    5'h19
`define PWTCP_A_ADCYC    5'h1A
`define PWTCP_A_ADBUF    5'h1B
`define PWTCP_A_PSTAT    5'h1C
`define PWTCP_B_RUN      0
`define PWTCP_B_CAPEN    0
`define PWTCP_B_CLREN    0
`define PWTCP_B_CRESTF   0
`define PWTCP_B_UNDF     1
`define PWTCP_B_ADF      2
`define PWTCP_B_SKCREN   3
`define PWTCP_B_SKUNEN   7
`define PWTCP_B_BTEN     0
`define PWTCP_B_BTLINK   1
`define PWTCP_B_ADEN     0
`define PWTCP_B_ADLINK   1
`define PWTCP_R_ZERO16   16'h0000
`define PWTCP_R_ONE16    16'h0001
`define PWTCP_R_UPLIM    16'hFFFF
`define PWTCP_R_HALF     16'hFFFF
`endif

// *** rtl/pwtcp_timer.v ***
// Purpose: pulse width measurement channel with three complementary pwm pairs
// Assumes: one clock, software at a plain register port
// Notes:   read data one cycle after the read strobe
//
// Behaviour
// RULE1 - 16-bit readable writable measurement counter counts enabled timer clock pulses.
// RULE2 - 16-bit clock select register picks the measurement counter clock prescale.
// RULE3 - 16-bit capture register receives the measured high duration.
// RULE4 - 8-bit io control register enables capture and sets input polarity.
// RULE5 - 8-bit interrupt enable register gates measurement channel requests.
// RULE6 - 8-bit start register starts or stops the measurement counter.
// RULE7 - 8-bit clear enable register allows clearing the counter after capture.
// RULE8 - 8-bit status register reports measurement channel flags.
// RULE9 - counter counts while input high, holds without clearing while low.
// RULE10 - crest match of first pwm counter captures measurement counter value.
// RULE11 - crest match sets flag and raises enabled interrupt request.
// RULE12 - software clears crest flag then reads the captured value.
// RULE13 - first counter turns down at upper limit, up at dead time.
// RULE14 - second counter turns down at half cycle, up at zero.
// RULE15 - buffer writes pass through hidden stages to compare registers.
// RULE16 - upper limit register holds half period, reloaded from its buffer.
// RULE17 - three duty compares set output pair duty, reloaded from buffers.
// RULE18 - dead time register; half cycle register reloads from its buffer.
// RULE19 - skipping setting skips crest and underflow interrupts, count up to seven.
// RULE20 - skip counter counts skipped interrupts, clears at programmed count.
// RULE21 - buffer transfer setting enables transfers and links them to skipping.
// RULE22 - converter start cycle match raises enabled request, reloads from buffer.
// RULE23 - counters stopped after reset; every crest overwrites the capture.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "pwtcp_consts.vh"
module pwtcp_timer #(
  parameter DW = 16
) (
  input  wire          sys_clk,
  input  wire          reset,
  input  wire [4:0]    regAddr,
  input  wire [DW-1:0] regWrData,
  input  wire          regWrStb,
  input  wire          regRdStb,
  output reg  [DW-1:0] regRdData,
  input  wire          pulseInputPin,
  output reg           crestIrq,
  output reg           underflowIrq,
  output reg           converterStartReq,
  output reg           pwmOutPairOnePos,
  output reg           pwmOutPairOneNeg,
  output reg           pwmOutPairTwoPos,
  output reg           pwmOutPairTwoNeg,
  output reg           pwmOutPairThreePos,
  output reg           pwmOutPairThreeNeg
);
  reg  [DW-1:0] measureCounter_reg;
  reg  [DW-1:0] measureClockSel_reg;
  reg  [DW-1:0] measureCapture_reg;
  reg  [7:0]    measureIoCtl_reg;
  reg  [7:0]    measureIntEn_reg;
  reg  [7:0]    measureStart_reg;
  reg  [7:0]    measureClrEn_reg;
  reg  [7:0]    measureStatus_reg;
  reg  [7:0]    pwmStart_reg;
  reg  [DW-1:0] cnt1_reg;
  reg  [DW-1:0] cnt2_reg;
  reg           down1_reg;
  reg           down2_reg;
  reg  [DW-1:0] upLim_reg;
  reg  [DW-1:0] upBuf_reg;
  reg  [DW-1:0] duty1_reg;
  reg  [DW-1:0] duty2_reg;
  reg  [DW-1:0] duty3_reg;
  reg  [DW-1:0] dBuf1_reg;
  reg  [DW-1:0] dBuf2_reg;
  reg  [DW-1:0] dBuf3_reg;
  reg  [DW-1:0] stage1_reg;
  reg  [DW-1:0] stage2_reg;
  reg  [DW-1:0] stage3_reg;
  reg  [DW-1:0] dead_reg;
  reg  [DW-1:0] half_reg;
  reg  [DW-1:0] hBuf_reg;
  reg  [7:0]    skipSet_reg;
  reg  [7:0]    skipCnt_reg;
  reg  [7:0]    btSet_reg;
  reg  [DW-1:0] adCtl_reg;
  reg  [DW-1:0] adCyc_reg;
  reg  [DW-1:0] adBuf_reg;
  reg  [7:0]    pwmStatus_reg;
  reg  [DW-1:0] prescale_reg;
  reg           pinSync1_reg;
  reg           pinSync2_reg;
  reg  [DW-1:0] rdData_next;
  wire          measureRun;
  wire          pwmRun;
  wire          measTick;
  wire          pinLevel;
  wire          crest;
  wire          trough;
  wire          skipOn;
  wire          skipHit;
  wire          skipStep;
  wire          crestPass;
  wire          underPass;
  wire          xferOk;
  wire          adMatch;
  wire          adPass;

  function wr;
    input [4:0] a;
    begin
      wr = regWrStb && (regAddr == a);
    end
  endfunction

  assign measureRun = measureStart_reg[`PWTCP_B_RUN]; // [RULE6] [RULE23]
  assign pwmRun     = pwmStart_reg[`PWTCP_B_RUN]; // [RULE23]
  // prescale 2**sel, sel 0 counts every cycle
  assign measTick   = (prescale_reg & ((`PWTCP_R_ONE16 << measureClockSel_reg[3:0])
                      - `PWTCP_R_ONE16)) == `PWTCP_R_ZERO16; // [RULE2]
  assign pinLevel   = pinSync2_reg ^ measureIoCtl_reg[1]; // [RULE4]
  assign crest      = pwmRun && !down1_reg && (cnt1_reg == upLim_reg); // [RULE13]
  assign trough     = pwmRun && down2_reg && (cnt2_reg == `PWTCP_R_ZERO16); // [RULE14]
  assign skipOn     = (skipSet_reg[`PWTCP_B_SKCREN] || skipSet_reg[`PWTCP_B_SKUNEN])
                      && (skipSet_reg[2:0] != 3'h0); // [RULE19]
  // full compare so a lowered count can never leave the counter above it
  assign skipHit    = skipCnt_reg >= {5'h00, skipSet_reg[2:0]}; // [RULE20]
  // only events whose skipping is enabled advance the counter
  assign skipStep   = (crest && skipSet_reg[`PWTCP_B_SKCREN])
                      || (trough && skipSet_reg[`PWTCP_B_SKUNEN]); // [RULE20]
  assign crestPass  = crest && (!skipOn || !skipSet_reg[`PWTCP_B_SKCREN] || skipHit);
  assign underPass  = trough && (!skipOn || !skipSet_reg[`PWTCP_B_SKUNEN] || skipHit);
  assign xferOk     = btSet_reg[`PWTCP_B_BTEN] &&
                      (!btSet_reg[`PWTCP_B_BTLINK] || !skipOn || skipHit); // [RULE21]
  assign adMatch    = pwmRun && adCtl_reg[`PWTCP_B_ADEN] && (cnt2_reg == adCyc_reg);
  assign adPass     = adMatch && (!adCtl_reg[`PWTCP_B_ADLINK] || !skipOn || skipHit); // [RULE22]

  always @(posedge sys_clk)
  begin
    pinSync1_reg <= pulseInputPin;
    pinSync2_reg <= pinSync1_reg;
  end

  always @*
  begin
    rdData_next = `PWTCP_R_ZERO16;
    case (regAddr)
      `PWTCP_A_MCNT:    rdData_next = measureCounter_reg;
      `PWTCP_A_MCLK:    rdData_next = measureClockSel_reg;
      `PWTCP_A_MCAP:    rdData_next = measureCapture_reg;
      `PWTCP_A_MIOC:    rdData_next = {8'h00, measureIoCtl_reg};
      `PWTCP_A_MIEN:    rdData_next = {8'h00, measureIntEn_reg};
      `PWTCP_A_MSTART:  rdData_next = {8'h00, measureStart_reg};
      `PWTCP_A_MCLREN:  rdData_next = {8'h00, measureClrEn_reg};
      `PWTCP_A_MSTAT:   rdData_next = {8'h00, measureStatus_reg};
      `PWTCP_A_PSTART:  rdData_next = {8'h00, pwmStart_reg};
      `PWTCP_A_CNT1:    rdData_next = cnt1_reg;
      `PWTCP_A_CNT2:    rdData_next = cnt2_reg;
      `PWTCP_A_UPLIM:   rdData_next = upLim_reg;
      `PWTCP_A_UPBUF:   rdData_next = upBuf_reg;
      `PWTCP_A_DUTY1:   rdData_next = duty1_reg;
      `PWTCP_A_DUTY2:   rdData_next = duty2_reg;
      `PWTCP_A_DUTY3:   rdData_next = duty3_reg;
      `PWTCP_A_DBUF1:   rdData_next = dBuf1_reg;
      `PWTCP_A_DBUF2:   rdData_next = dBuf2_reg;
      `PWTCP_A_DBUF3:   rdData_next = dBuf3_reg;
      `PWTCP_A_DEAD:    rdData_next = dead_reg;
      `PWTCP_A_HALF:    rdData_next = half_reg;
      `PWTCP_A_HBUF:    rdData_next = hBuf_reg;
      `PWTCP_A_SKIPSET: rdData_next = {8'h00, skipSet_reg};
      `PWTCP_A_SKIPCNT: rdData_next = {8'h00, skipCnt_reg};
      `PWTCP_A_BTSET:   rdData_next = {8'h00, btSet_reg};
      `PWTCP_A_ADCTL:   rdData_next = adCtl_reg;
      `PWTCP_A_ADCYC:   rdData_next = adCyc_reg;
      `PWTCP_A_ADBUF:   rdData_next = adBuf_reg;
      `PWTCP_A_PSTAT:   rdData_next = {8'h00, pwmStatus_reg};
      default:          rdData_next = `PWTCP_R_ZERO16;
    endcase
  end

  // register port and measurement channel
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      regRdData           <= `PWTCP_R_ZERO16;
      measureCounter_reg  <= `PWTCP_R_ZERO16;
      measureClockSel_reg <= `PWTCP_R_ZERO16;
      measureCapture_reg  <= `PWTCP_R_ZERO16;
      measureIoCtl_reg    <= 8'h00;
      measureIntEn_reg    <= 8'h00;
      measureStart_reg    <= 8'h00;
      measureClrEn_reg    <= 8'h00;
      measureStatus_reg   <= 8'h00;
      pwmStart_reg        <= 8'h00;
      prescale_reg        <= `PWTCP_R_ZERO16;
      crestIrq            <= 1'b0;
    end
    else
    begin
      regRdData <= regRdStb ? rdData_next : `PWTCP_R_ZERO16;
      if (wr(`PWTCP_A_MCLK))   measureClockSel_reg <= regWrData; // [RULE2]
      if (wr(`PWTCP_A_MIOC))   measureIoCtl_reg <= regWrData[7:0]; // [RULE4]
      if (wr(`PWTCP_A_MIEN))   measureIntEn_reg <= regWrData[7:0]; // [RULE5]
      if (wr(`PWTCP_A_MSTART)) measureStart_reg <= regWrData[7:0]; // [RULE6]
      if (wr(`PWTCP_A_MCLREN)) measureClrEn_reg <= regWrData[7:0]; // [RULE7]
      if (wr(`PWTCP_A_PSTART)) pwmStart_reg <= regWrData[7:0];
      prescale_reg <= measureRun ? prescale_reg + `PWTCP_R_ONE16 : `PWTCP_R_ZERO16;
      if (wr(`PWTCP_A_MCNT))
        measureCounter_reg <= regWrData; // [RULE1]
      else if (crest && measureIoCtl_reg[`PWTCP_B_CAPEN] && measureClrEn_reg[`PWTCP_B_CLREN])
        measureCounter_reg <= `PWTCP_R_ZERO16; // [RULE7]
      else if (measureRun && measTick && pinLevel)
        measureCounter_reg <= measureCounter_reg + `PWTCP_R_ONE16; // [RULE1] [RULE9]
      if (crest && measureIoCtl_reg[`PWTCP_B_CAPEN])
        measureCapture_reg <= measureCounter_reg; // [RULE10] [RULE23]
      else if (wr(`PWTCP_A_MCAP))
        measureCapture_reg <= regWrData; // [RULE3]
      // set wins over software clear
      if (crest)
        measureStatus_reg[`PWTCP_B_CRESTF] <= 1'b1; // [RULE11]
      else if (wr(`PWTCP_A_MSTAT) && !regWrData[`PWTCP_B_CRESTF])
        measureStatus_reg[`PWTCP_B_CRESTF] <= 1'b0; // [RULE8] [RULE12]
      crestIrq <= crestPass && measureIntEn_reg[0]; // [RULE5] [RULE11] [RULE19]
    end
  end

  // three complementary pwm pairs
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      cnt1_reg <= `PWTCP_R_ZERO16;
      cnt2_reg <= `PWTCP_R_ZERO16;
      down1_reg <= 1'b0;
      down2_reg <= 1'b0;
      upLim_reg <= `PWTCP_R_UPLIM;
      upBuf_reg <= `PWTCP_R_UPLIM;
      duty1_reg <= `PWTCP_R_ZERO16;
      duty2_reg <= `PWTCP_R_ZERO16;
      duty3_reg <= `PWTCP_R_ZERO16;
      dBuf1_reg <= `PWTCP_R_ZERO16;
      dBuf2_reg <= `PWTCP_R_ZERO16;
      dBuf3_reg <= `PWTCP_R_ZERO16;
      stage1_reg <= `PWTCP_R_ZERO16;
      stage2_reg <= `PWTCP_R_ZERO16;
      stage3_reg <= `PWTCP_R_ZERO16;
      dead_reg <= `PWTCP_R_ZERO16;
      half_reg <= `PWTCP_R_HALF;
      hBuf_reg <= `PWTCP_R_HALF;
      skipSet_reg <= 8'h00;
      skipCnt_reg <= 8'h00;
      btSet_reg <= 8'h00;
      adCtl_reg <= `PWTCP_R_ZERO16;
      adCyc_reg <= `PWTCP_R_ZERO16;
      adBuf_reg <= `PWTCP_R_ZERO16;
      pwmStatus_reg <= 8'h00;
      underflowIrq <= 1'b0;
      converterStartReq <= 1'b0;
      pwmOutPairOnePos <= 1'b0;
      pwmOutPairOneNeg <= 1'b0;
      pwmOutPairTwoPos <= 1'b0;
      pwmOutPairTwoNeg <= 1'b0;
      pwmOutPairThreePos <= 1'b0;
      pwmOutPairThreeNeg <= 1'b0;
    end
    else
    begin
      if (wr(`PWTCP_A_UPBUF)) upBuf_reg <= regWrData; // [RULE16]
      if (wr(`PWTCP_A_DBUF1)) dBuf1_reg <= regWrData; // [RULE17]
      if (wr(`PWTCP_A_DBUF2)) dBuf2_reg <= regWrData;
      if (wr(`PWTCP_A_DBUF3)) dBuf3_reg <= regWrData;
      if (wr(`PWTCP_A_DEAD))  dead_reg <= regWrData; // [RULE18]
      if (wr(`PWTCP_A_HBUF))  hBuf_reg <= regWrData; // [RULE18]
      if (wr(`PWTCP_A_SKIPSET)) skipSet_reg <= regWrData[7:0]; // [RULE19]
      if (wr(`PWTCP_A_BTSET)) btSet_reg <= regWrData[7:0]; // [RULE21]
      if (wr(`PWTCP_A_ADCTL)) adCtl_reg <= regWrData; // [RULE22]
      if (wr(`PWTCP_A_ADBUF)) adBuf_reg <= regWrData;
      // stopped: direct writes of counters and compares
      if (!pwmRun)
      begin
        if (wr(`PWTCP_A_CNT1))  cnt1_reg <= regWrData;
        if (wr(`PWTCP_A_CNT2))  cnt2_reg <= regWrData;
        if (wr(`PWTCP_A_UPLIM)) upLim_reg <= regWrData;
        // stage follows a direct write so a later turn keeps the compare
        if (wr(`PWTCP_A_DUTY1))
        begin
          duty1_reg  <= regWrData;
          stage1_reg <= regWrData; // [RULE15]
        end
        if (wr(`PWTCP_A_DUTY2))
        begin
          duty2_reg  <= regWrData;
          stage2_reg <= regWrData; // [RULE15]
        end
        if (wr(`PWTCP_A_DUTY3))
        begin
          duty3_reg  <= regWrData;
          stage3_reg <= regWrData; // [RULE15]
        end
        if (wr(`PWTCP_A_HALF))  half_reg <= regWrData;
        if (wr(`PWTCP_A_ADCYC)) adCyc_reg <= regWrData;
        down1_reg <= 1'b0;
        down2_reg <= 1'b0;
      end
      else
      begin
        if (crest) down1_reg <= 1'b1; // [RULE13]
        else if (down1_reg && cnt1_reg == dead_reg) down1_reg <= 1'b0; // [RULE13]
        cnt1_reg <= (crest || (down1_reg && cnt1_reg != dead_reg)) ?
                    cnt1_reg - `PWTCP_R_ONE16 : cnt1_reg + `PWTCP_R_ONE16;
        if (!down2_reg && cnt2_reg == half_reg) down2_reg <= 1'b1; // [RULE14]
        else if (trough) down2_reg <= 1'b0; // [RULE14]
        cnt2_reg <= ((!down2_reg && cnt2_reg == half_reg) || (down2_reg && !trough)) ?
                    cnt2_reg - `PWTCP_R_ONE16 : cnt2_reg + `PWTCP_R_ONE16;
        if (xferOk)
        begin
          stage1_reg <= dBuf1_reg; // [RULE15]
          stage2_reg <= dBuf2_reg;
          stage3_reg <= dBuf3_reg;
        end
        if (crest || trough)
        begin
          duty1_reg <= stage1_reg; // [RULE15] [RULE17]
          duty2_reg <= stage2_reg;
          duty3_reg <= stage3_reg;
          upLim_reg <= upBuf_reg; // [RULE16]
          half_reg  <= hBuf_reg; // [RULE18]
          adCyc_reg <= adBuf_reg; // [RULE22]
          if (skipOn && skipStep)
            skipCnt_reg <= skipHit ? 8'h00 : skipCnt_reg + 8'h01; // [RULE20]
        end
      end
      if (!skipOn) skipCnt_reg <= 8'h00;
      if (trough)
        pwmStatus_reg[`PWTCP_B_UNDF] <= 1'b1;
      else if (wr(`PWTCP_A_PSTAT) && !regWrData[`PWTCP_B_UNDF])
        pwmStatus_reg[`PWTCP_B_UNDF] <= 1'b0;
      if (adPass)
        pwmStatus_reg[`PWTCP_B_ADF] <= 1'b1;
      else if (wr(`PWTCP_A_PSTAT) && !regWrData[`PWTCP_B_ADF])
        pwmStatus_reg[`PWTCP_B_ADF] <= 1'b0;
      underflowIrq <= underPass && measureIntEn_reg[1]; // [RULE19]
      converterStartReq <= adPass; // [RULE22]
      pwmOutPairOnePos   <= pwmRun && (cnt2_reg > duty1_reg); // [RULE17]
      pwmOutPairOneNeg   <= pwmRun && (cnt2_reg + dead_reg < duty1_reg);
      pwmOutPairTwoPos   <= pwmRun && (cnt2_reg > duty2_reg);
      pwmOutPairTwoNeg   <= pwmRun && (cnt2_reg + dead_reg < duty2_reg);
      pwmOutPairThreePos <= pwmRun && (cnt2_reg > duty3_reg);
      pwmOutPairThreeNeg <= pwmRun && (cnt2_reg + dead_reg < duty3_reg);
    end
  end
endmodule

// *** sim/pwtcp_timer_props.sv ***
// Purpose: port assertions for the pulse width timer
// Assumes: sees the top ports only
// Notes:   pwm run state rebuilt from register writes
`timescale 1ns/1ps
`include "pwtcp_consts.vh"
module pwtcp_timer_props #(
  parameter DW = 16
) (
  input wire          sys_clk,
  input wire          reset,
  input wire [4:0]    regAddr,
  input wire [DW-1:0] regWrData,
  input wire          regWrStb,
  input wire          regRdStb,
  input wire [DW-1:0] regRdData,
  input wire          pulseInputPin,
  input wire          crestIrq,
  input wire          underflowIrq,
  input wire          converterStartReq,
  input wire          pwmOutPairOnePos,
  input wire          pwmOutPairOneNeg,
  input wire          pwmOutPairTwoPos,
  input wire          pwmOutPairTwoNeg,
  input wire          pwmOutPairThreePos,
  input wire          pwmOutPairThreeNeg
);
  reg       runFlag_reg;
  reg [3:0] stopCnt_reg;
  wire      byteAddr = regAddr == `PWTCP_A_MIOC || regAddr == `PWTCP_A_MIEN
                    || regAddr == `PWTCP_A_MSTART || regAddr == `PWTCP_A_MCLREN
                    || regAddr == `PWTCP_A_MSTAT;
  wire      anyOut = pwmOutPairOnePos | pwmOutPairOneNeg | pwmOutPairTwoPos
                   | pwmOutPairTwoNeg | pwmOutPairThreePos | pwmOutPairThreeNeg
                   | crestIrq | underflowIrq | converterStartReq;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // pwm run state and cycles since stop
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      runFlag_reg <= 1'b0;
      stopCnt_reg <= 4'h0;
    end
    else
    begin
      if (regWrStb && regAddr == `PWTCP_A_PSTART)
        runFlag_reg <= regWrData[0];
      if (runFlag_reg)
        stopCnt_reg <= 4'h0;
      else if (stopCnt_reg != 4'hF)
        stopCnt_reg <= stopCnt_reg + 4'h1;
    end
  end
  chk_read_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 16'h0000)
    else $error("read data not zero outside read cycle");
  chk_hidden_unmapped: assert property ($past(regRdStb) && $past(regAddr) > `PWTCP_A_PSTAT
    |-> regRdData == 16'h0000) else $error("unmapped read not zero");
  chk_byte_upper_zero: assert property ($past(regRdStb) && $past(byteAddr)
    |-> regRdData[15:8] == 8'h00) else $error("byte register upper bits set");
  chk_skip_count_max: assert property ($past(regRdStb) && $past(regAddr) == `PWTCP_A_SKIPCNT
    |-> regRdData <= 16'h0007) else $error("skip counter above seven");
  chk_crest_one_cycle: assert property (crestIrq |=> !crestIrq)
    else $error("crest request longer than one cycle");
  chk_under_one_cycle: assert property ($rose(underflowIrq) |=> $fell(underflowIrq))
    else $error("underflow request longer than one cycle");
  chk_adc_one_cycle: assert property (converterStartReq |=> !converterStartReq [*2])
    else $error("converter request repeated");
  chk_reset_quiet: assert property ($past(reset) |-> !anyOut)
    else $error("outputs active right after reset");
  chk_stop_quiet: assert property (stopCnt_reg >= 4'h3 |-> !anyOut)
    else $error("outputs active while pwm stopped");
endmodule

// *** sim/pwtcp_pulse_src.sv ***
// Purpose: external pulse source driving the measured input
// Assumes: fire is a one-cycle request
// Notes:   output high for exactly highLen cycles, low otherwise
`timescale 1ns/1ps
module pwtcp_pulse_src (
  input  wire        sys_clk,
  input  wire        fire,
  input  wire [15:0] highLen,
  output reg         pulseOut
);
  reg [15:0] left_reg = 16'h0000;
  initial pulseOut = 1'b0;
  always @(posedge sys_clk)
  begin
    if (fire)
      left_reg <= highLen;
    else if (left_reg != 16'h0000)
      left_reg <= left_reg - 16'h0001;
    pulseOut <= fire ? (highLen != 16'h0000) : (left_reg > 16'h0001);
  end
endmodule

// *** sim/test_pwtcp_timer.sv ***
// Purpose: self-checking bench for the pulse width timer
// Assumes: plain register port, one clock
// Notes:   pwm runs with small limits to keep periods short
`timescale 1ns/1ps
`include "pwtcp_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_pwtcp_timer;
  reg         sys_clk = 1'b0;
  reg         reset = 1'b1;
  reg  [4:0]  regAddr = 5'h00;
  reg  [15:0] regWrData = 16'h0000;
  reg         regWrStb = 1'b0;
  reg         regRdStb = 1'b0;
  reg         fire = 1'b0;
  reg  [15:0] highLen = 16'h0000;
  reg  [15:0] v;
  wire [15:0] regRdData;
  wire        pulsePin, crestIrq, underflowIrq, converterStartReq;
  wire [5:0]  pwmOut;
  int         n_fail = 0;
  int         check_count = 0;
  int         tick = 0;
  int         c, nc, nu, na, np, nn;
  always #2 sys_clk = ~sys_clk;
  pwtcp_timer pwtcp_timer_i (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .pulseInputPin(pulsePin), .crestIrq(crestIrq), .underflowIrq(underflowIrq),
    .converterStartReq(converterStartReq), .pwmOutPairOnePos(pwmOut[0]),
    .pwmOutPairOneNeg(pwmOut[1]), .pwmOutPairTwoPos(pwmOut[2]), .pwmOutPairTwoNeg(pwmOut[3]),
    .pwmOutPairThreePos(pwmOut[4]), .pwmOutPairThreeNeg(pwmOut[5]));
  pwtcp_pulse_src pwtcp_pulse_src_i (.sys_clk(sys_clk), .fire(fire), .highLen(highLen),
    .pulseOut(pulsePin));
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    tick++;
    if (tick == 30000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  task wr(input [4:0] a, input [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask
  task rd(input [4:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 v = regRdData;
  endtask
  task chk_rd(input [4:0] a, input [15:0] e);
    rd(a);
    `CHK(v, e)
  endtask
  task wait_irq(input int s, output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    while ((s == 0 ? crestIrq : underflowIrq) !== 1'b1);
  endtask
  task count_win(input int len);
    nc = 0;
    nu = 0;
    na = 0;
    np = 0;
    nn = 0;
    repeat (len)
    begin
      @(posedge sys_clk);
      #1 nc += (crestIrq === 1'b1);
      nu += (underflowIrq === 1'b1);
      na += (converterStartReq === 1'b1);
      np += (pwmOut[0] === 1'b1);
      nn += (pwmOut[1] === 1'b1);
    end
  endtask
  task pulse(input [15:0] n);
    @(posedge sys_clk);
    highLen <= n;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (n + 10) @(posedge sys_clk);
  endtask
  task t_reset;
    chk_rd(`PWTCP_A_UPLIM, 16'hFFFF);
    chk_rd(`PWTCP_A_HALF, 16'hFFFF);
    chk_rd(`PWTCP_A_MCNT, 16'h0000);
    chk_rd(`PWTCP_A_MSTART, 16'h0000);
    chk_rd(5'h1D, 16'h0000);
  endtask
  task t_regs;
    reg [4:0] adr [6] = '{`PWTCP_A_MCLK, `PWTCP_A_MCAP, `PWTCP_A_DEAD,
                          `PWTCP_A_MIOC, `PWTCP_A_MIEN, `PWTCP_A_MCLREN};
    for (int i = 0; i < 6; i++)
    begin
      wr(adr[i], 16'hA5C3);
      chk_rd(adr[i], i < 3 ? 16'hA5C3 : 16'h00C3);
      wr(adr[i], 16'h0000);
    end
  endtask
  task t_measure;
    for (int p = 0; p < 3; p++)
    begin
      wr(`PWTCP_A_MCLK, 16'(p));
      wr(`PWTCP_A_MCNT, 16'h0000);
      wr(`PWTCP_A_MSTART, 16'h0001);
      pulse(16'd20);
      chk_rd(`PWTCP_A_MCNT, 16'(20 >> p));
      pulse(16'd8);
      chk_rd(`PWTCP_A_MCNT, 16'(28 >> p));
      wr(`PWTCP_A_MSTART, 16'h0000);
    end
    pulse(16'd8);
    chk_rd(`PWTCP_A_MCNT, 16'd7);
    wr(`PWTCP_A_MCLK, 16'h0000);
  endtask
  task t_crest;
    wr(`PWTCP_A_DEAD, 16'd4);
    wr(`PWTCP_A_UPLIM, 16'd40);
    wr(`PWTCP_A_UPBUF, 16'd40);
    wr(`PWTCP_A_HALF, 16'd36);
    wr(`PWTCP_A_HBUF, 16'd36);
    wr(`PWTCP_A_CNT1, 16'd4);
    wr(`PWTCP_A_DUTY1, 16'd8);
    wr(`PWTCP_A_DBUF1, 16'd8);
    wr(`PWTCP_A_MCNT, 16'h1234);
    wr(`PWTCP_A_MIOC, 16'h0001);
    wr(`PWTCP_A_MIEN, 16'h0003);
    wr(`PWTCP_A_PSTART, 16'h0001);
    wait_irq(0, c);
    wait_irq(0, c);
    `CHK(c, 72)
    wait_irq(1, c);
    wait_irq(1, c);
    `CHK(c, 72)
    chk_rd(`PWTCP_A_MSTAT, 16'h0001);
    wr(`PWTCP_A_MSTAT, 16'h0000);
    chk_rd(`PWTCP_A_MSTAT, 16'h0000);
    chk_rd(`PWTCP_A_MCAP, 16'h1234);
    wr(`PWTCP_A_MCLREN, 16'h0001);
    wait_irq(0, c);
    wait_irq(0, c);
    chk_rd(`PWTCP_A_MCNT, 16'h0000);
    chk_rd(`PWTCP_A_MCAP, 16'h0000);
  endtask
  task t_buffer;
    wr(`PWTCP_A_DBUF1, 16'h0010);
    wr(`PWTCP_A_UPLIM, 16'h0050);
    wait_irq(0, c);
    wait_irq(0, c);
    chk_rd(`PWTCP_A_DUTY1, 16'd8);
    chk_rd(`PWTCP_A_UPLIM, 16'd40);
    wr(`PWTCP_A_BTSET, 16'h0001);
    wr(`PWTCP_A_UPBUF, 16'd60);
    wr(`PWTCP_A_HBUF, 16'd56);
    wait_irq(0, c);
    wait_irq(0, c);
    chk_rd(`PWTCP_A_DUTY1, 16'h0010);
    chk_rd(`PWTCP_A_UPLIM, 16'd60);
    chk_rd(`PWTCP_A_HALF, 16'd56);
    wait_irq(0, c);
    wait_irq(0, c);
    `CHK(c, 112)
  endtask
  task t_skip_adc;
    wr(`PWTCP_A_ADCTL, 16'h0001);
    wr(`PWTCP_A_ADBUF, 16'd20);
    wait_irq(0, c);
    wait_irq(0, c);
    chk_rd(`PWTCP_A_ADCYC, 16'd20);
    wr(`PWTCP_A_SKIPSET, 16'h000B);
    count_win(12 * 112);
    `CHK(nu, 12)
    `CHK((nc == 3 || nc == 4), 1'b1)
    `CHK((na == 12 || na == 24), 1'b1)
    `CHK(np, 948)
    `CHK(nn, 276)
    rd(`PWTCP_A_SKIPCNT);
    `CHK((v <= 16'd3), 1'b1)
    wr(`PWTCP_A_ADCTL, 16'h0000);
    @(posedge sys_clk);
    count_win(224);
    `CHK(na, 0)
    wr(`PWTCP_A_PSTART, 16'h0000);
    repeat (5) @(posedge sys_clk);
    `CHK(pwmOut, 6'h00)
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset;
    t_regs;
    t_measure;
    t_crest;
    t_buffer;
    t_skip_adc;
    report_and_stop;
  end
endmodule
bind pwtcp_timer pwtcp_timer_props #(.DW(DW)) pwtcp_timer_props_i (.sys_clk(sys_clk),
  .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
  .regRdStb(regRdStb), .regRdData(regRdData), .pulseInputPin(pulseInputPin),
  .crestIrq(crestIrq), .underflowIrq(underflowIrq), .converterStartReq(converterStartReq),
  .pwmOutPairOnePos(pwmOutPairOnePos), .pwmOutPairOneNeg(pwmOutPairOneNeg),
  .pwmOutPairTwoPos(pwmOutPairTwoPos), .pwmOutPairTwoNeg(pwmOutPairTwoNeg),
  .pwmOutPairThreePos(pwmOutPairThreePos), .pwmOutPairThreeNeg(pwmOutPairThreeNeg));
